// ===== src/psc_regs.sv
/*
  Register bank of a supply switch controller: control, alert enables, live
  status, sticky fault log and three ADC result registers, reached through a
  byte link sampled on the rising edge of its own clock.
  Assumes a protocol engine outside presents one operation per link clock
  rising edge, with op, broadcast flag and data stable around that edge.
*/
`timescale 1ns/1ns
// Summary of operation
// - only pointer bits 2:0 decode; pointers 6 and 7 both reach aux result
// - ADC result registers take writes only while test mode is set
// - test mode halts ADC updates; test mode bit resets to zero
// - bits 7:6 pick power-good, output bit, power-bad or input on pin
// - output mode drives pin from alert register bit 6, reset zero
// - broadcast-address writes accepted only while mass write bit set, reset one
// - switch control bit one turns pass switch on, zero turns it off
// - retry per fault only when enabled; overcurrent off, under/over on at reset
// - alert pulled low on logged fault only if its enable is set
// - status bit 7 shows switch on
// - status bit 6 shows live level of the general pin
// - status bit 5 shows sense above 2mV with switch off
// - status bit 4 shows card detect low
// - status bit 3 shows output feedback low
// - status bit 2 shows overcurrent cool-down in progress
// - status bit 1 shows undervoltage input low
// - status bit 0 shows overvoltage input high
// - fault bit 5 set when sense result exceeds 7 with switch off
// - fault bit 4 set on any card detect change
// - fault bit 3 set when output feedback falls
// - fault bit 2 set on overcurrent fault
// - fault bit 1 on undervoltage falling, bit 0 on overvoltage rising
// - command byte low bits latch into pointer, kept after transaction
// - no new alert for a class whose fault bit is still set
// - alert released when device is individually addressed
module psc_regs
  import psc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       lnk_clk,
  input  wire logic [1:0] lnk_op,
  input  wire logic       lnk_bcast,
  input  wire logic [7:0] lnk_wdata,
  output logic      [7:0] lnk_rdata,
  input  wire logic       card_detect_input,
  input  wire logic       output_feedback_input,
  input  wire logic       undervoltage_input,
  input  wire logic       overvoltage_input,
  input  wire logic       gpio_pin_in,
  output logic            gpio_pin_out,
  output logic            gpio_pin_oe,
  output logic            alert_out,
  output logic            alert_oe,
  input  wire logic       oc_fault_pulse,
  input  wire logic       oc_cooldown,
  input  wire logic       adc_valid,
  input  wire logic [7:0] adc_sense,
  input  wire logic [7:0] adc_source,
  input  wire logic [7:0] adc_aux,
  output logic            adc_halt,
  output logic            switch_on,
  output logic            retry_oc_en,
  output logic            retry_uv_en,
  output logic            retry_ov_en
);

  typedef struct packed {
    logic [2:0] ptr;
    logic [7:0] ctrl;
    logic [7:0] alrt;
    logic [7:0] fault;
    logic [7:0] sense;
    logic [7:0] src;
    logic [7:0] aux;
    logic [7:0] rdata;
    logic       alert_pull;
    logic       gpio_out;
    logic       gpio_oe;
    logic       adc_halt;
    logic       sw_on;
    logic       r_oc;
    logic       r_uv;
    logic       r_ov;
  } psc_regs_st_t;

  localparam psc_regs_st_t ST_RST = '{
    ptr: PTR_RST, ctrl: CTRL_RST, alrt: ALERT_RST, fault: FAULT_RST,
    sense: ADC_RST, src: ADC_RST, aux: ADC_RST, rdata: 8'h00,
    alert_pull: 1'b0, gpio_out: 1'b0, gpio_oe: 1'b0, adc_halt: 1'b0,
    sw_on: 1'b0, r_oc: 1'b0, r_uv: 1'b1, r_ov: 1'b1
  };

  psc_regs_st_t        st_q;
  psc_regs_st_t        st_d;
  logic                lnk_edge_w;
  logic [1:0]          op_w;
  logic                bc_w;
  logic [7:0]          wd_w;
  logic                accept_w;
  logic                addressed_w;
  logic                wr_w;
  logic                rd_w;
  logic [NUM_REGS-1:0] sel_w;
  logic [7:0]          status_w;
  logic [7:0]          events_w;
  logic [7:0]          fault_rise_w;
  logic [7:0]          new_alert_w;
  logic                short_now_w;

  psc_sync_if sy ();

  assign sy.raw = {gpio_pin_in, overvoltage_input, undervoltage_input,
                   output_feedback_input, card_detect_input, lnk_wdata,
                   lnk_bcast, lnk_op, lnk_clk};

  psc_sync u_sync (
    .clk_sys (clk_sys),
    .srst    (srst),
    .sy      (sy)
  );

  // one-hot register select; pointer 7 aliases the aux result
  function automatic logic [NUM_REGS-1:0] reg_sel(input logic [2:0] p);
    logic [NUM_REGS-1:0] s;
    s = '0;
    case (p)
      REG_CTRL:      s = 7'h01;
      REG_ALERT:     s = 7'h02;
      REG_STATUS:    s = 7'h04;
      REG_FAULT:     s = 7'h08;
      REG_SENSE:     s = 7'h10;
      REG_SOURCE:    s = 7'h20;
      REG_AUX:       s = 7'h40;
      REG_AUX_ALIAS: s = 7'h40;
      default:       s = 7'h00;
    endcase
    return s;
  endfunction

  always_comb begin
    st_d        = st_q;
    lnk_edge_w  = sy.rise[SY_LCLK];
    op_w        = sy.lvl[SY_OP +: 2];
    bc_w        = sy.lvl[SY_BC];
    wd_w        = sy.lvl[SY_DATA +: 8];
    accept_w    = lnk_edge_w && (op_w != OP_IDLE) && (!bc_w || st_q.ctrl[CTL_MASS]);
    addressed_w = lnk_edge_w && (op_w != OP_IDLE) && !bc_w;
    wr_w        = accept_w && (op_w == OP_WR);
    // broadcast reads would collide on the wire, so only direct reads answer
    rd_w        = addressed_w && (op_w == OP_RD);
    sel_w       = reg_sel(st_q.ptr);
    short_now_w = (st_q.sense > SHORT_CODE) && !st_q.ctrl[CTL_SWITCH];

    status_w[ST_SWITCH] = st_q.sw_on;
    status_w[ST_GPIO]   = sy.lvl[SY_GPIO];
    status_w[F_SHORT]   = short_now_w;
    status_w[F_CARD]    = !sy.lvl[SY_CARD];
    status_w[F_PBAD]    = !sy.lvl[SY_FB];
    status_w[F_OC]      = oc_cooldown;
    status_w[F_UV]      = !sy.lvl[SY_UV];
    status_w[F_OV]      = sy.lvl[SY_OV];

    events_w[F_SHORT] = short_now_w;
    events_w[F_CARD]  = sy.rise[SY_CARD] || sy.fall[SY_CARD];
    events_w[F_PBAD]  = sy.fall[SY_FB];
    events_w[F_OC]    = oc_fault_pulse;
    events_w[F_UV]    = sy.fall[SY_UV];
    events_w[F_OV]    = sy.rise[SY_OV];
    events_w[7:6]     = 2'h0;

    if (accept_w && (op_w == OP_CMD)) begin
      st_d.ptr = wd_w[2:0];
    end

    if (adc_valid && !st_q.ctrl[CTL_TEST]) begin
      st_d.sense = adc_sense;
      st_d.src   = adc_source;
      st_d.aux   = adc_aux;
    end

    if (wr_w) begin
      if (sel_w[0]) begin
        st_d.ctrl = wd_w;
      end
      if (sel_w[1]) begin
        st_d.alrt = wd_w & ALERT_MASK;
      end
      // writing zero clears a bit, writing one keeps it
      if (sel_w[3]) begin
        st_d.fault = st_q.fault & wd_w;
      end
      // ADC results writable in test mode only
      if (st_q.ctrl[CTL_TEST]) begin
        if (sel_w[4]) begin
          st_d.sense = wd_w;
        end
        if (sel_w[5]) begin
          st_d.src = wd_w;
        end
        if (sel_w[6]) begin
          st_d.aux = wd_w;
        end
      end
    end

    // a fault event in the clearing cycle still lands
    st_d.fault = (st_d.fault | events_w) & FAULT_MASK;

    // only a bit going from clear to set can raise an alert
    fault_rise_w = st_d.fault & ~st_q.fault;
    new_alert_w  = fault_rise_w & st_q.alrt & FAULT_MASK;

    // release when addressed; a fresh alert in the same cycle wins
    if (addressed_w) begin
      st_d.alert_pull = 1'b0;
    end
    if (|new_alert_w) begin
      st_d.alert_pull = 1'b1;
    end

    if (rd_w) begin
      st_d.rdata = ({8{sel_w[0]}} & st_q.ctrl)  | ({8{sel_w[1]}} & st_q.alrt)
                 | ({8{sel_w[2]}} & status_w)   | ({8{sel_w[3]}} & st_q.fault)
                 | ({8{sel_w[4]}} & st_q.sense) | ({8{sel_w[5]}} & st_q.src)
                 | ({8{sel_w[6]}} & st_q.aux);
    end

    st_d.sw_on    = st_q.ctrl[CTL_SWITCH];
    // retry enables to the fault timers
    st_d.r_oc     = st_q.ctrl[CTL_RETRY_OC];
    st_d.r_uv     = st_q.ctrl[CTL_RETRY_UV];
    st_d.r_ov     = st_q.ctrl[CTL_RETRY_OV];
    st_d.adc_halt = st_q.ctrl[CTL_TEST];

    case (st_q.ctrl[CTL_GPIO_HI:CTL_GPIO_LO])
      GP_PGOOD: begin
        st_d.gpio_out = !status_w[F_PBAD];
        st_d.gpio_oe  = 1'b1;
      end
      GP_PBAD: begin
        st_d.gpio_out = status_w[F_PBAD];
        st_d.gpio_oe  = 1'b1;
      end
      GP_OUT: begin
        st_d.gpio_out = st_q.alrt[ALR_GPIO_OUT];
        st_d.gpio_oe  = 1'b1;
      end
      default: begin
        st_d.gpio_out = 1'b0;
        st_d.gpio_oe  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign lnk_rdata    = st_q.rdata;
  assign gpio_pin_out = st_q.gpio_out;
  assign gpio_pin_oe  = st_q.gpio_oe;
  // open-drain: the pin is only ever pulled low
  assign alert_out    = 1'b0;
  assign alert_oe     = st_q.alert_pull;
  assign adc_halt     = st_q.adc_halt;
  assign switch_on    = st_q.sw_on;
  assign retry_oc_en  = st_q.r_oc;
  assign retry_uv_en  = st_q.r_uv;
  assign retry_ov_en  = st_q.r_ov;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  sequence s_cmd_taken;
    accept_w && (op_w == OP_CMD);
  endsequence

  sequence s_locked_sense_write;
    wr_w && sel_w[4] && !st_q.ctrl[CTL_TEST] && !adc_valid;
  endsequence

  sequence s_ctrl_write;
    wr_w && sel_w[0];
  endsequence

  sequence s_status_read;
    rd_w && sel_w[2];
  endsequence

  a_ptr_latch: assert property (s_cmd_taken |=> st_q.ptr == $past(wd_w[2:0]))
    else $error("pointer did not take command byte low bits");

  a_ptr_hold: assert property (!(accept_w && op_w == OP_CMD) |=> $stable(st_q.ptr))
    else $error("pointer changed without a command byte");

  a_alias_read: assert property (rd_w && st_q.ptr == REG_AUX_ALIAS
    |=> lnk_rdata == $past(st_q.aux))
    else $error("pointer 7 did not read the aux result");

  a_adc_lock: assert property (s_locked_sense_write |=> $stable(st_q.sense))
    else $error("sense result written outside test mode");

  a_adc_freeze: assert property (st_q.ctrl[CTL_TEST] && !wr_w
    |=> $stable(st_q.sense) && $stable(st_q.src) && $stable(st_q.aux))
    else $error("ADC result changed while halted");

  a_gpio_mode: assert property (1'b1
    |=> gpio_pin_oe == ($past(st_q.ctrl[CTL_GPIO_HI:CTL_GPIO_LO]) != GP_IN))
    else $error("general pin drive does not follow its mode");

  a_gpio_data: assert property (st_q.ctrl[CTL_GPIO_HI:CTL_GPIO_LO] == GP_OUT
    |=> gpio_pin_out == $past(st_q.alrt[ALR_GPIO_OUT]))
    else $error("general pin does not show the output bit");

  a_mass_ignore: assert property (lnk_edge_w && bc_w && !st_q.ctrl[CTL_MASS]
    |=> $stable(st_q.ctrl) && $stable(st_q.ptr) && $stable(st_q.alrt))
    else $error("broadcast access taken with mass write off");

  a_switch_follow: assert property (s_ctrl_write
    |=> ##1 switch_on == $past(wd_w[CTL_SWITCH], 2))
    else $error("switch did not follow the control bit");

  a_retry_follow: assert property (1'b1
    |=> {retry_oc_en, retry_uv_en, retry_ov_en} == $past(st_q.ctrl[CTL_RETRY_OC:CTL_RETRY_OV]))
    else $error("retry enables do not follow control");

  a_alert_cause: assert property ($rose(st_q.alert_pull) |-> $past(|new_alert_w, 1))
    else $error("alert raised without an enabled new fault");

  a_alert_once: assert property (!st_q.alert_pull && fault_rise_w == 8'h00
    |=> !st_q.alert_pull)
    else $error("alert raised for an already logged fault");

  a_alert_release: assert property (addressed_w && new_alert_w == 8'h00
    |=> !st_q.alert_pull)
    else $error("alert not released when addressed");

  a_status_read: assert property (s_status_read |=> lnk_rdata == $past(status_w))
    else $error("status read does not show live condition");

  a_short_log: assert property (short_now_w |=> st_q.fault[F_SHORT])
    else $error("shorted switch not logged");

  a_card_log: assert property (sy.rise[SY_CARD] || sy.fall[SY_CARD] |=> st_q.fault[F_CARD])
    else $error("card change not logged");

  a_supply_log: assert property ((sy.fall[SY_UV] |=> st_q.fault[F_UV])
    and (sy.rise[SY_OV] |=> st_q.fault[F_OV]) and (sy.fall[SY_FB] |=> st_q.fault[F_PBAD]))
    else $error("supply fault not logged");

  a_fault_sticky: assert property (st_q.fault[F_OC] && !(wr_w && sel_w[3])
    |=> st_q.fault[F_OC])
    else $error("fault bit cleared without a host write");

endmodule

// ===== src/psc_pkg.sv
/*
  Constants for the power switch controller register bank: register pointers,
  field positions, reset values, link operation codes and synchroniser layout.
  Assumes nothing of its surroundings; imported whole by every design file.
*/
package psc_pkg;

  // register pointer values (low three bits of the command byte)
  localparam logic [2:0] REG_CTRL      = 3'h0;
  localparam logic [2:0] REG_ALERT     = 3'h1;
  localparam logic [2:0] REG_STATUS    = 3'h2;
  localparam logic [2:0] REG_FAULT     = 3'h3;
  localparam logic [2:0] REG_SENSE     = 3'h4;
  localparam logic [2:0] REG_SOURCE    = 3'h5;
  localparam logic [2:0] REG_AUX       = 3'h6;
  localparam logic [2:0] REG_AUX_ALIAS = 3'h7;
  localparam int         NUM_REGS      = 7;
  localparam logic [2:0] PTR_RST       = 3'h0;

  // control_config fields
  localparam int CTL_GPIO_HI  = 7;
  localparam int CTL_GPIO_LO  = 6;
  localparam int CTL_TEST     = 5;
  localparam int CTL_MASS     = 4;
  localparam int CTL_SWITCH   = 3;
  localparam int CTL_RETRY_OC = 2;
  localparam int CTL_RETRY_UV = 1;
  localparam int CTL_RETRY_OV = 0;
  localparam logic [7:0] CTRL_RST = 8'h13;

  // general pin function, as {bit7, bit6}
  localparam logic [1:0] GP_PGOOD = 2'h0;
  localparam logic [1:0] GP_OUT   = 2'h1;
  localparam logic [1:0] GP_PBAD  = 2'h2;
  localparam logic [1:0] GP_IN    = 2'h3;

  // alert_enable fields
  localparam int         ALR_GPIO_OUT = 6;
  localparam logic [7:0] ALERT_RST    = 8'h00;
  localparam logic [7:0] ALERT_MASK   = 8'h7F;

  // fault_log / alert enable / status bit positions shared by fault classes
  localparam int         F_SHORT    = 5;
  localparam int         F_CARD     = 4;
  localparam int         F_PBAD     = 3;
  localparam int         F_OC       = 2;
  localparam int         F_UV       = 1;
  localparam int         F_OV       = 0;
  localparam int         ST_SWITCH  = 7;
  localparam int         ST_GPIO    = 6;
  localparam logic [7:0] FAULT_RST  = 8'h00;
  localparam logic [7:0] FAULT_MASK = 8'h3F;
  localparam logic [7:0] ADC_RST    = 8'h00;

  // current sense code above which a shorted switch is suspected
  localparam logic [7:0] SHORT_CODE = 8'h07;

  // link operation codes presented with each link clock rising edge
  localparam logic [1:0] OP_IDLE = 2'h0;
  localparam logic [1:0] OP_CMD  = 2'h1;
  localparam logic [1:0] OP_WR   = 2'h2;
  localparam logic [1:0] OP_RD   = 2'h3;

  // layout of the synchronised input vector
  localparam int SY_LCLK = 0;
  localparam int SY_OP   = 1;
  localparam int SY_BC   = 3;
  localparam int SY_DATA = 4;
  localparam int SY_CARD = 12;
  localparam int SY_FB   = 13;
  localparam int SY_UV   = 14;
  localparam int SY_OV   = 15;
  localparam int SY_GPIO = 16;
  localparam int SY_W    = 17;

  // cycles after reset before edges are trusted
  localparam logic [1:0] PRIME_CYCLES = 2'h3;

endpackage

// ===== src/psc_sync_if.sv
/*
  Carrier between the register bank and its input synchroniser: raw pin
  levels in, synchronised levels and edge pulses out.
  Assumes the psc_pkg package is compiled first.
*/
`timescale 1ns/1ns
interface psc_sync_if;
  import psc_pkg::*;
  logic [SY_W-1:0] raw;
  logic [SY_W-1:0] lvl;
  logic [SY_W-1:0] rise;
  logic [SY_W-1:0] fall;
  modport src (input raw, output lvl, output rise, output fall);
  modport snk (output raw, input lvl, input rise, input fall);
endinterface

// ===== src/psc_sync.sv
/*
  Two-flop synchroniser with edge detection for every asynchronous input of
  the register bank, the link clock among them.
  Assumes clk_sys runs much faster than any input toggles (link clock period 130 ns).
*/
`timescale 1ns/1ns
module psc_sync
  import psc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  psc_sync_if.src  sy
);

  typedef struct packed {
    logic [SY_W-1:0] s1;
    logic [SY_W-1:0] s2;
    logic [SY_W-1:0] s3;
    logic [1:0]      cnt;
  } psc_sync_st_t;

  psc_sync_st_t st_q;
  psc_sync_st_t st_d;
  logic         primed;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = sy.raw;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.cnt != PRIME_CYCLES) begin
      st_d.cnt = st_q.cnt + 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // edges are suppressed until s3 holds real data, so reset is no false change
  assign primed  = (st_q.cnt == PRIME_CYCLES);
  assign sy.lvl  = st_q.s2;
  assign sy.rise = st_q.s2 & ~st_q.s3 & {SY_W{primed}};
  assign sy.fall = ~st_q.s2 & st_q.s3 & {SY_W{primed}};

endmodule

// ===== testbench/psc_host_model.sv
/*
  Host-side model of the register link: each operation is framed by one
  link clock pulse, and read data is captured before that pulse ends.
  Assumes the register bank samples op, flag and data on the link rising edge.
*/
`timescale 1ns/1ns
module psc_host_model
  import psc_pkg::*;
(
  input  wire logic       clk_sys,
  output logic            lnk_clk,
  output logic      [1:0] lnk_op,
  output logic            lnk_bcast,
  output logic      [7:0] lnk_wdata,
  input  wire logic [7:0] lnk_rdata
);
  initial begin
    lnk_clk   = 1'b0;
    lnk_op    = OP_IDLE;
    lnk_bcast = 1'b0;
    lnk_wdata = 8'h00;
  end

  task automatic xfer(input logic [1:0] op, input logic bc, input logic [7:0] d,
                      output logic [7:0] rd);
    @(negedge clk_sys);
    lnk_op    = op;
    lnk_bcast = bc;
    lnk_wdata = d;
    #62;
    lnk_clk = 1'b1;
    // fall lands between clk_sys edges, never on a sampling edge
    #58;
    rd = lnk_rdata;
    #3;
    lnk_clk = 1'b0;
    // released data shows the inverse so a stale byte never passes as fresh
    lnk_op    = OP_IDLE;
    lnk_wdata = ~d;
  endtask
endmodule

// ===== testbench/tb_power_switch_ctrl_regs.sv
/*
  Self-checking bench for the register bank: table of register accesses,
  then hand-written cases for ADC halt, faults, alerts, pin modes, mass write.
  Assumes psc_pkg, the design files and psc_host_model are compiled first.
*/
`timescale 1ns/1ns
module tb_power_switch_ctrl_regs;
  import psc_pkg::*;

  typedef struct packed {
    logic [7:0] cmd;
    logic       wr;
    logic [7:0] data;
    logic [7:0] exp;
  } psc_row_t;

  logic       clk_sys = 1'b0;
  logic       srst = 1'b1;
  logic       lnk_clk, lnk_bcast, gpio_pin_in, gpio_pin_out, gpio_pin_oe;
  logic [1:0] lnk_op;
  logic [7:0] lnk_wdata, lnk_rdata, rd;
  logic       card_detect_input = 1'b1;
  logic       output_feedback_input = 1'b1;
  logic       undervoltage_input = 1'b1;
  logic       overvoltage_input = 1'b0;
  logic       gp_ext = 1'b1;
  logic       oc_fault_pulse = 1'b0;
  logic       oc_cooldown = 1'b0;
  logic       adc_valid = 1'b0;
  logic [7:0] adc_sense = 8'h00;
  logic [7:0] adc_source = 8'h00;
  logic [7:0] adc_aux = 8'h00;
  logic       alert_out, alert_oe, adc_halt, switch_on;
  logic       retry_oc_en, retry_uv_en, retry_ov_en;
  int         err_total = 0;
  int         tests_run = 0;

  psc_row_t rows [15] = '{
    '{8'h00, 1'b0, 8'h00, 8'h13}, '{8'h01, 1'b0, 8'h00, 8'h00},
    '{8'h03, 1'b0, 8'h00, 8'h00}, '{8'h04, 1'b0, 8'h00, 8'h00},
    '{8'h05, 1'b0, 8'h00, 8'h00}, '{8'h06, 1'b0, 8'h00, 8'h00},
    '{8'h01, 1'b1, 8'hFF, 8'h7F}, '{8'h03, 1'b1, 8'hFF, 8'h00},
    '{8'h04, 1'b1, 8'h5A, 8'h00}, '{8'hF8, 1'b1, 8'h33, 8'h33},
    '{8'h0C, 1'b1, 8'h05, 8'h05}, '{8'h06, 1'b1, 8'hA5, 8'hA5},
    '{8'h07, 1'b0, 8'h00, 8'hA5}, '{8'h05, 1'b1, 8'h3C, 8'h3C},
    '{8'h02, 1'b1, 8'hFF, 8'h40}};
  logic [7:0] mctl [4] = '{8'h1C, 8'h9A, 8'h59, 8'hD8};
  logic [1:0] mpin [4] = '{2'h3, 2'h2, 2'h3, 2'h0};

  // the general pin wire: the design drives it when enabled, else the board does
  assign gpio_pin_in = gpio_pin_oe ? gpio_pin_out : gp_ext;

  always #5 clk_sys = ~clk_sys;

  psc_regs i_dut (
    .clk_sys, .srst, .lnk_clk, .lnk_op, .lnk_bcast, .lnk_wdata, .lnk_rdata,
    .card_detect_input, .output_feedback_input, .undervoltage_input,
    .overvoltage_input, .gpio_pin_in, .gpio_pin_out, .gpio_pin_oe, .alert_out,
    .alert_oe, .oc_fault_pulse, .oc_cooldown, .adc_valid, .adc_sense, .adc_source,
    .adc_aux, .adc_halt, .switch_on, .retry_oc_en, .retry_uv_en, .retry_ov_en
  );

  psc_host_model i_host (
    .clk_sys, .lnk_clk, .lnk_op, .lnk_bcast, .lnk_wdata, .lnk_rdata
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rd_reg(input logic [7:0] cmd, output logic [7:0] v);
    i_host.xfer(OP_CMD, 1'b0, cmd, v);
    i_host.xfer(OP_RD, 1'b0, 8'h00, v);
  endtask

  task automatic wr_reg(input logic [7:0] cmd, input logic [7:0] d);
    logic [7:0] v;
    i_host.xfer(OP_CMD, 1'b0, cmd, v);
    i_host.xfer(OP_WR, 1'b0, d, v);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic adc_pulse(input logic [7:0] s, input logic [7:0] o, input logic [7:0] a);
    @(negedge clk_sys);
    adc_sense  = s;
    adc_source = o;
    adc_aux    = a;
    adc_valid  = 1'b1;
    @(negedge clk_sys);
    adc_valid = 1'b0;
    wait_n(3);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // a hung link or a lost completion must still end the run with a verdict
  initial begin
    #300000;
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    wait_n(2);
    srst = 1'b0;
    chk({4'h0, alert_out, gpio_pin_oe, switch_on, alert_oe}, 8'h00, "outputs in reset");
    wait_n(6);
    for (int i = 0; i < 15; i++) begin
      if (rows[i].wr) begin
        wr_reg(rows[i].cmd, rows[i].data);
      end
      rd_reg(rows[i].cmd, rd);
      chk(rd, rows[i].exp, "register row");
    end
    chk({7'h00, adc_halt}, 8'h01, "adc halted");
    adc_pulse(8'h09, 8'h02, 8'h03);
    rd_reg(8'h04, rd);
    chk(rd, 8'h05, "sense kept in test mode");
    wr_reg(8'h00, 8'h13);
    chk({7'h00, adc_halt}, 8'h00, "adc running");
    adc_pulse(8'h08, 8'h11, 8'h22);
    chk({7'h00, alert_oe}, 8'h01, "short alert");
    rd_reg(8'h06, rd);
    chk(rd, 8'h22, "aux updated");
    i_host.xfer(OP_RD, 1'b0, 8'h00, rd);
    chk(rd, 8'h22, "pointer kept");
    chk({7'h00, alert_oe}, 8'h00, "alert released");
    rd_reg(8'h02, rd);
    chk(rd, 8'h60, "short status");
    rd_reg(8'h03, rd);
    chk(rd, 8'h20, "short logged");
    adc_pulse(8'h07, 8'h11, 8'h22);
    rd_reg(8'h02, rd);
    chk(rd, 8'h40, "short boundary");
    wr_reg(8'h03, 8'h00);
    rd_reg(8'h03, rd);
    chk(rd, 8'h00, "fault cleared");
    @(negedge clk_sys);
    {card_detect_input, output_feedback_input, undervoltage_input} = 3'h0;
    overvoltage_input = 1'b1;
    oc_cooldown = 1'b1;
    oc_fault_pulse = 1'b1;
    @(negedge clk_sys);
    oc_fault_pulse = 1'b0;
    wait_n(6);
    chk({7'h00, alert_oe}, 8'h01, "fault alert");
    rd_reg(8'h02, rd);
    chk(rd, 8'h1F, "live faults");
    rd_reg(8'h03, rd);
    chk(rd, 8'h1F, "faults logged");
    @(negedge clk_sys);
    card_detect_input = 1'b1;
    wait_n(6);
    chk({7'h00, alert_oe}, 8'h00, "no repeat alert");
    wr_reg(8'h03, 8'hEF);
    @(negedge clk_sys);
    card_detect_input = 1'b0;
    wait_n(6);
    chk({7'h00, alert_oe}, 8'h01, "alert after clear");
    rd_reg(8'h03, rd);
    chk(rd, 8'h1F, "card change relogged");
    @(negedge clk_sys);
    {card_detect_input, output_feedback_input, undervoltage_input} = 3'h7;
    overvoltage_input = 1'b0;
    oc_cooldown = 1'b0;
    gp_ext = 1'b0;
    wait_n(6);
    wr_reg(8'h03, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr_reg(8'h00, mctl[m]);
      wait_n(3);
      chk({6'h00, gpio_pin_oe, gpio_pin_in}, {6'h00, mpin[m]}, "pin function");
      chk({4'h0, switch_on, retry_oc_en, retry_uv_en, retry_ov_en},
          {4'h0, mctl[m][3:0]}, "switch and retry");
      rd_reg(8'h02, rd);
      chk(rd, {1'b1, mpin[m][0], 6'h00}, "status pin");
    end
    wr_reg(8'h00, 8'h10);
    rd_reg(8'h02, rd);
    chk(rd, 8'h40, "switch off");
    i_host.xfer(OP_CMD, 1'b1, 8'h01, rd);
    i_host.xfer(OP_WR, 1'b1, 8'h05, rd);
    rd_reg(8'h01, rd);
    chk(rd, 8'h05, "mass write taken");
    wr_reg(8'h00, 8'h03);
    i_host.xfer(OP_WR, 1'b1, 8'hFF, rd);
    rd_reg(8'h00, rd);
    chk(rd, 8'h03, "mass write ignored");
    wr_reg(8'h00, 8'h2C);
    @(negedge clk_sys);
    srst = 1'b1;
    wait_n(2);
    srst = 1'b0;
    chk({2'h0, switch_on, adc_halt, alert_oe, retry_oc_en, retry_uv_en, retry_ov_en},
        8'h03, "outputs after reset");
    wait_n(6);
    rd_reg(8'h00, rd);
    chk(rd, 8'h13, "control after reset");
    rd_reg(8'h01, rd);
    chk(rd, 8'h00, "alert after reset");
    end_of_test();
  end
endmodule
